// *** rtl/twm_defs.svh ***
`ifndef TWM_DEFS_SVH
`define TWM_DEFS_SVH
// Register byte offsets
`define TWM_OFF_CTRL 8'h00
`define TWM_OFF_STAT 8'h04
`define TWM_OFF_DATA 8'h08
`define TWM_OFF_DIV 8'h0C
// Control register bit positions
`define TWM_B_FLAG 7
`define TWM_B_ACK 6
`define TWM_B_STA 5
`define TWM_B_STO 4
`define TWM_B_WCOL 3
`define TWM_B_EN 2
`define TWM_B_IE 0
// Status codes (prescaler bits zero)
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_DT_ACK 8'h28
`define TWM_ST_DT_NACK 8'h30
`define TWM_ST_ARB 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_DR_ACK 8'h50
`define TWM_ST_DR_NACK 8'h58
`define TWM_ST_IDLE 8'hF8
// Reset values
`define TWM_RST_CTRL 8'h00
`define TWM_RST_DATA 8'hFF
`define TWM_RST_DIV 8'h0F
// Bus clock: 50 MHz system clock, 100 kHz default bus (quarter-period ticks)
`define TWM_CLK_HZ 50000000
`define TWM_BUS_HZ 100000
`define TWM_QTR_CYC (`TWM_CLK_HZ / (4 * `TWM_BUS_HZ))
`endif

// *** rtl/twm_pkg.sv ***
package twm_pkg;
  typedef enum logic [3:0] {
    TWM_IDLE, TWM_WAIT_FREE, TWM_START, TWM_HOLD, TWM_BIT, TWM_ACK, TWM_STOP, TWM_RELEASE
  } twm_state_t;
  typedef enum logic [1:0] {TWM_OP_NONE, TWM_OP_TX, TWM_OP_RX} twm_op_t;
endpackage

// *** rtl/twm_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser per bit; first stage feeds only the second
module twm_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end else begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[i] = sync_reg;
    end
  endgenerate
endmodule // twm_sync

// *** rtl/twm_engine.sv ***
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "twm_defs.svh"
// Functional notes
// (RQ1) Data sent, ACK received: set flag, status 0x28.
// (RQ2) Data sent, NACK received: set flag, status 0x30.
// (RQ3) In 0x28/0x30 new byte plus flag clear sends it and samples ACK.
// (RQ4) Flag clear with start only issues repeated START.
// (RQ5) Flag clear with stop only issues STOP, then stop request self-clears.
// (RQ6) Flag clear with start and stop issues STOP then START, stop self-clears.
// (RQ7) Arbitration lost in address-write or data: set flag, status 0x38.
// (RQ8) In 0x38 plain clear releases bus, not-addressed slave state.
// (RQ9) In 0x38 clear with start waits for free bus, then START.
// (RQ10) Flag, start and enable written one begins transfer once bus free.
// (RQ11) After START placed: set flag, status 0x08.
// (RQ12) Software loads address-read then clears flag to enter receive.
// (RQ13) After address-read and ACK bit: set flag, report 0x38/0x40/0x48.
// (RQ14) Received byte is in data register whenever flag is set.
// (RQ15) Software NACKs the final byte, then ends with STOP or START.
// (RQ16) Address direction bit selects master transmit or master receive.
// (RQ17) After repeated START (0x10) any slave, any direction, no STOP.
// (RQ18) Writing one to flag clears it; enable must be one to operate. The code clears the flag only if enable is written one too.
// (RQ19) Software masks prescaler bits of status before decoding.
// (RQ20) Data write with flag low is discarded and sets write collision.
// (RQ21) In 0x40/0x50 ack enable chooses ACK or NACK for next byte.
// (RQ22) While flag set, serial clock is held low.
module twm_engine #(
  parameter int QTR_CYC = `TWM_QTR_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Two-wire bus, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  twm_pkg::twm_state_t state_reg;
  twm_pkg::twm_op_t op_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] stat_reg;
  logic [7:0] data_reg;
  logic [7:0] div_reg;
  logic [15:0] tick_cnt_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_cnt_reg;
  logic rx_mode_reg;
  logic addr_phase_reg;
  logic restart_pending_reg;
  logic started_reg;
  logic busy_reg;
  logic scl_drv_low_reg;
  logic sda_drv_low_reg;
  logic ack_bit_reg;
  logic [1:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic tick;
  logic wr_fire;
  logic ctrl_wr;
  logic flag_clear;
  logic hw_set;
  logic sto_done;

  twm_sync #(.WIDTH(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_sync)
  );
  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // Bus-idle tracking: START/STOP seen by anyone on the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      if (scl_s && scl_d_reg && sda_d_reg && !sda_s)
        busy_reg <= 1'b1;
      else if (scl_s && scl_d_reg && !sda_d_reg && sda_s)
        busy_reg <= 1'b0;
    end
  end

  // AXI4-Lite write side: address and data accepted in either order
  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign ctrl_wr = wr_fire && (aw_addr_reg == `TWM_OFF_CTRL) && w_strb_reg[0];
  assign flag_clear = ctrl_wr && w_data_reg[`TWM_B_FLAG] && w_data_reg[`TWM_B_EN]; // [RQ18]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg > `TWM_OFF_DIV) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case ({s_axi_araddr[7:2], 2'b00})
        `TWM_OFF_CTRL: s_axi_rdata <= {24'h00_0000, ctrl_reg};
        `TWM_OFF_STAT: s_axi_rdata <= {24'h00_0000, stat_reg};
        `TWM_OFF_DATA: s_axi_rdata <= {24'h00_0000, data_reg};
        `TWM_OFF_DIV: s_axi_rdata <= {24'h00_0000, div_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Control register: hardware flag set wins over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `TWM_RST_CTRL;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg[`TWM_B_ACK] <= w_data_reg[`TWM_B_ACK];
        ctrl_reg[`TWM_B_STA] <= w_data_reg[`TWM_B_STA];
        ctrl_reg[`TWM_B_STO] <= w_data_reg[`TWM_B_STO];
        ctrl_reg[`TWM_B_EN] <= w_data_reg[`TWM_B_EN]; // [RQ18]
        ctrl_reg[`TWM_B_IE] <= w_data_reg[`TWM_B_IE];
        if (w_data_reg[`TWM_B_FLAG])
          ctrl_reg[`TWM_B_WCOL] <= 1'b0;
      end
      if (flag_clear)
        ctrl_reg[`TWM_B_FLAG] <= 1'b0; // [RQ18]
      if (wr_fire && aw_addr_reg == `TWM_OFF_DATA && w_strb_reg[0] && !ctrl_reg[`TWM_B_FLAG])
        ctrl_reg[`TWM_B_WCOL] <= 1'b1; // [RQ20]
      if (sto_done)
        ctrl_reg[`TWM_B_STO] <= 1'b0; // [RQ5] [RQ6]
      if (hw_set)
        ctrl_reg[`TWM_B_FLAG] <= 1'b1;
    end
  end

  // Divider register: stored for software only, bit timing runs from QTR_CYC
  always_ff @(posedge aclk) begin
    if (!aresetn)
      div_reg <= `TWM_RST_DIV;
    else if (wr_fire && aw_addr_reg == `TWM_OFF_DIV && w_strb_reg[0])
      div_reg <= w_data_reg[7:0];
  end

  assign tick = (tick_cnt_reg == 16'h0000);
  always_ff @(posedge aclk) begin
    if (!aresetn || state_reg == twm_pkg::TWM_IDLE || state_reg == twm_pkg::TWM_HOLD)
      tick_cnt_reg <= 16'(QTR_CYC - 1);
    else if (tick)
      tick_cnt_reg <= 16'(QTR_CYC - 1);
    else if (!(scl_drv_low_reg == 1'b0 && !scl_s && phase_reg != 2'd0))
      tick_cnt_reg <= tick_cnt_reg - 16'h0001;
  end

  // Bus engine: quarter-bit phases, 9 bits per byte including acknowledge
  assign sto_done = (state_reg == twm_pkg::TWM_STOP) && tick && phase_reg == 2'd3;
  always_ff @(posedge aclk) begin
    hw_set <= 1'b0;
    if (!aresetn) begin
      state_reg <= twm_pkg::TWM_IDLE;
      op_reg <= twm_pkg::TWM_OP_NONE;
      stat_reg <= `TWM_ST_IDLE;
      data_reg <= `TWM_RST_DATA;
      phase_reg <= 2'd0;
      bit_cnt_reg <= 4'h0;
      rx_mode_reg <= 1'b0;
      addr_phase_reg <= 1'b0;
      restart_pending_reg <= 1'b0;
      started_reg <= 1'b0;
      scl_drv_low_reg <= 1'b0;
      sda_drv_low_reg <= 1'b0;
      ack_bit_reg <= 1'b1;
      hw_set <= 1'b0;
    end else begin
      if (wr_fire && aw_addr_reg == `TWM_OFF_DATA && w_strb_reg[0] && ctrl_reg[`TWM_B_FLAG])
        data_reg <= w_data_reg[7:0];
      case (state_reg)
        twm_pkg::TWM_IDLE: begin
          scl_drv_low_reg <= 1'b0;
          sda_drv_low_reg <= 1'b0;
          if (flag_clear && w_data_reg[`TWM_B_STA])
            state_reg <= twm_pkg::TWM_WAIT_FREE; // [RQ10]
        end
        twm_pkg::TWM_WAIT_FREE: begin
          phase_reg <= 2'd0;
          // We still own the bus for a repeated START, so our own START must not block it
          if ((!busy_reg || started_reg) && scl_s && sda_s)
            state_reg <= twm_pkg::TWM_START; // [RQ9] [RQ10]
        end
        twm_pkg::TWM_START: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          case (phase_reg)
            2'd0: sda_drv_low_reg <= 1'b0;
            2'd1: scl_drv_low_reg <= 1'b0;
            2'd2: sda_drv_low_reg <= 1'b1;
            default: begin
              scl_drv_low_reg <= 1'b1;
              stat_reg <= started_reg ? `TWM_ST_RSTART : `TWM_ST_START; // [RQ11] [RQ17]
              started_reg <= 1'b1;
              addr_phase_reg <= 1'b1;
              hw_set <= 1'b1;
              state_reg <= twm_pkg::TWM_HOLD;
            end
          endcase
        end
        twm_pkg::TWM_HOLD: begin
          scl_drv_low_reg <= 1'b1; // [RQ22]
          phase_reg <= 2'd0;
          bit_cnt_reg <= 4'h0;
          if (flag_clear) begin
            if (stat_reg == `TWM_ST_ARB) begin
              started_reg <= 1'b0;
              scl_drv_low_reg <= 1'b0; // [RQ8]
              sda_drv_low_reg <= 1'b0;
              state_reg <= w_data_reg[`TWM_B_STA] ? twm_pkg::TWM_WAIT_FREE : twm_pkg::TWM_IDLE; // [RQ9]
            end else if (w_data_reg[`TWM_B_STO]) begin
              restart_pending_reg <= w_data_reg[`TWM_B_STA]; // [RQ6]
              state_reg <= twm_pkg::TWM_STOP; // [RQ5]
            end else if (w_data_reg[`TWM_B_STA]) begin
              scl_drv_low_reg <= 1'b0;
              sda_drv_low_reg <= 1'b0;
              state_reg <= twm_pkg::TWM_WAIT_FREE; // [RQ4]
            end else begin
              if (addr_phase_reg)
                rx_mode_reg <= data_reg[0]; // [RQ16] [RQ12]
              ack_bit_reg <= ~w_data_reg[`TWM_B_ACK]; // [RQ21]
              state_reg <= twm_pkg::TWM_BIT; // [RQ3]
            end
          end
        end
        twm_pkg::TWM_BIT: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          case (phase_reg)
            2'd0: begin
              if (rx_mode_reg && !addr_phase_reg)
                sda_drv_low_reg <= 1'b0;
              else
                sda_drv_low_reg <= ~data_reg[7];
            end
            2'd1: scl_drv_low_reg <= 1'b0;
            2'd2: begin
              if (!(rx_mode_reg && !addr_phase_reg) && data_reg[7] && !sda_s) begin
                stat_reg <= `TWM_ST_ARB; // [RQ7]
                sda_drv_low_reg <= 1'b0;
                hw_set <= 1'b1;
                state_reg <= twm_pkg::TWM_HOLD;
              end
              data_reg <= {data_reg[6:0], sda_s}; // [RQ14]
            end
            default: begin
              scl_drv_low_reg <= 1'b1;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == 4'h7)
                state_reg <= twm_pkg::TWM_ACK;
            end
          endcase
        end
        twm_pkg::TWM_ACK: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          case (phase_reg)
            2'd0: sda_drv_low_reg <= (rx_mode_reg && !addr_phase_reg) ? ~ack_bit_reg : 1'b0;
            2'd1: scl_drv_low_reg <= 1'b0;
            2'd2: begin
              if (addr_phase_reg && rx_mode_reg)
                stat_reg <= sda_s ? `TWM_ST_AR_NACK : `TWM_ST_AR_ACK; // [RQ13]
              else if (addr_phase_reg)
                stat_reg <= sda_s ? `TWM_ST_AW_NACK : `TWM_ST_AW_ACK;
              else if (rx_mode_reg)
                stat_reg <= ack_bit_reg ? `TWM_ST_DR_NACK : `TWM_ST_DR_ACK;
              else
                stat_reg <= sda_s ? `TWM_ST_DT_NACK : `TWM_ST_DT_ACK; // [RQ1] [RQ2]
            end
            default: begin
              scl_drv_low_reg <= 1'b1;
              sda_drv_low_reg <= 1'b0;
              addr_phase_reg <= 1'b0;
              op_reg <= rx_mode_reg ? twm_pkg::TWM_OP_RX : twm_pkg::TWM_OP_TX;
              hw_set <= 1'b1;
              state_reg <= twm_pkg::TWM_HOLD;
            end
          endcase
        end
        twm_pkg::TWM_STOP: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          case (phase_reg)
            2'd0: sda_drv_low_reg <= 1'b1;
            2'd1: scl_drv_low_reg <= 1'b0;
            2'd2: sda_drv_low_reg <= 1'b0;
            default: begin
              started_reg <= 1'b0;
              op_reg <= twm_pkg::TWM_OP_NONE;
              stat_reg <= `TWM_ST_IDLE;
              restart_pending_reg <= 1'b0;
              state_reg <= restart_pending_reg ? twm_pkg::TWM_WAIT_FREE : twm_pkg::TWM_IDLE; // [RQ6]
            end
          endcase
        end
        default: state_reg <= twm_pkg::TWM_IDLE;
      endcase
      if (!ctrl_reg[`TWM_B_EN] && !flag_clear) begin
        state_reg <= twm_pkg::TWM_IDLE;
        started_reg <= 1'b0;
      end
    end
  end

  // Open-drain drive: enable high while pulling low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= scl_drv_low_reg;
      sda_oe <= sda_drv_low_reg;
    end
  end
endmodule // twm_engine

// *** verif/twm_assertions.sv ***
`timescale 1ns/1ps
module twm_assertions #(
  parameter int QTR_CYC = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Two-wire bus
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Data line moves while the clock line is released
  sequence s_start;
    $rose(sda_oe) && !scl_oe && !$past(scl_oe);
  endsequence
  sequence s_stop;
    $fell(sda_oe) && !scl_oe && !$past(scl_oe);
  endsequence
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h03
    |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)) else $error("unmapped read");
  a_reset_quiet: assert property ($rose(aresetn) |-> !scl_oe && !sda_oe && !s_axi_bvalid && !s_axi_rvalid)
    else $error("not idle after reset");
  a_pull_only: assert property (scl_out == 1'b0 && sda_out == 1'b0) else $error("wire driven high");
  a_start_hold: assert property (s_start |-> ##[1:40] scl_oe) else $error("clock not held after start");
  a_stop_free: assert property (s_stop |=> !scl_oe [*2]) else $error("clock pulled after stop");
endmodule // twm_assertions

bind twm_engine twm_assertions #(.QTR_CYC(QTR_CYC)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe));

// *** verif/twm_slave_model.sv ***
`timescale 1ns/1ps
module twm_slave_model (
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  // Behaviour
  input wire logic ack_on,
  // Drive and observation
  output logic sda_oe,
  output logic [7:0] rx_byte,
  output logic [7:0] stop_cnt
);
  logic [7:0] sh, tx;
  logic [3:0] cnt;
  logic adr, rdm, inbus;
  initial begin
    sda_oe = 1'b0;
    rx_byte = 8'h00;
    stop_cnt = 8'h00;
    sh = 8'h00;
    tx = 8'hC3;
    cnt = 4'h0;
    adr = 1'b0;
    rdm = 1'b0;
    inbus = 1'b0;
  end
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      inbus = 1'b1;
      cnt = 4'h0;
      adr = 1'b1;
      rdm = 1'b0;
    end
  end
  // Wires leave X at power-up; only a stop after a start counts
  always @(posedge sda) begin
    if (scl === 1'b1 && inbus) begin
      inbus = 1'b0;
      stop_cnt = stop_cnt + 8'h01;
      rdm = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (cnt < 4'h8) begin
      sh = {sh[6:0], sda};
      cnt = cnt + 4'h1;
    end else if (cnt == 4'h8) begin
      if (rdm) tx = tx + 8'h01;
      // A refused byte ends our sending
      if (rdm && sda) rdm = 1'b0;
      cnt = 4'h9;
    end
  end
  // Line changes only while the clock is low, so no false start or stop
  always @(negedge scl) begin
    if (cnt == 4'h8) begin
      rx_byte = sh;
      sda_oe = ack_on && !rdm;
    end else if (cnt == 4'h9) begin
      cnt = 4'h0;
      if (adr) rdm = sh[0] && ack_on;
      adr = 1'b0;
      sda_oe = rdm && !tx[7];
    end else begin
      sda_oe = rdm && !tx[3'd7 - cnt[2:0]];
    end
  end
endmodule // twm_slave_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, rx_byte, stop_cnt;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, brsp, rrsp;
  logic scl_out, scl_oe, sda_out, sda_oe, m_sda_oe, ack_on, rival;
  wire scl_w = !scl_oe;
  wire sda_w = !(sda_oe || m_sda_oe || rival);
  int failures, num_checks;
  twm_engine #(.QTR_CYC(4)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  twm_slave_model model (.scl(scl_w), .sda(sda_w), .ack_on(ack_on), .sda_oe(m_sda_oe), .rx_byte(rx_byte),
    .stop_cnt(stop_cnt));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    brsp = bresp;
    bready <= 1'b0;
    if (n >= 100) failures++;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    rdat = rdata;
    rrsp = rresp;
    rready <= 1'b0;
    if (n >= 100) failures++;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdat, exp);
  endtask
  // Software polls the flag; the engine offers no interrupt line
  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(8'h00);
      n++;
    end while (rdat[b] !== v && n < 300);
    if (n >= 300) failures++;
  endtask
  task automatic step(input logic ld, input logic [7:0] d, input logic [7:0] c, input logic [7:0] st);
    if (ld) wr(8'h08, d);
    wr(8'h00, c);
    wait_bit(7, 1'b1);
    rd_chk(8'h04, {24'h0, st});
  endtask
  initial begin
    #1000000;
    failures++;
    test_done;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rival} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    ack_on = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h00, 32'h00);
    rd_chk(8'h04, 32'hF8);
    rd_chk(8'h0C, 32'h0F);
    rd(8'h10);
    chk({30'h0, rrsp}, 32'h2);
    wr(8'h10, 8'h00);
    chk({30'h0, brsp}, 32'h2);
    wr(8'h08, 8'h55);
    rd_chk(8'h00, 32'h08);
    rd_chk(8'h08, 32'hFF);
    step(1'b0, 8'h00, 8'hA4, 8'h08);
    step(1'b1, 8'hA0, 8'h84, 8'h18);
    step(1'b1, 8'h5A, 8'h84, 8'h28);
    chk({24'h0, rx_byte}, 32'h5A);
    ack_on <= 1'b0;
    step(1'b1, 8'h3C, 8'h84, 8'h30);
    ack_on <= 1'b1;
    step(1'b0, 8'h00, 8'hA4, 8'h10);
    chk({24'h0, stop_cnt}, 32'h0);
    step(1'b1, 8'hA1, 8'h84, 8'h40);
    step(1'b0, 8'h00, 8'hC4, 8'h50);
    rd_chk(8'h08, 32'hC3);
    step(1'b0, 8'h00, 8'h84, 8'h58);
    rd_chk(8'h08, 32'hC4);
    wr(8'h00, 8'h94);
    wait_bit(4, 1'b0);
    repeat (20) @(posedge aclk);
    chk({24'h0, stop_cnt}, 32'h1);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    step(1'b0, 8'h00, 8'hA4, 8'h08);
    ack_on <= 1'b0;
    step(1'b1, 8'hA1, 8'h84, 8'h48);
    ack_on <= 1'b1;
    step(1'b0, 8'h00, 8'hB4, 8'h08);
    chk({24'h0, stop_cnt}, 32'h2);
    rd(8'h00);
    chk({31'h0, rdat[4]}, 32'h0);
    step(1'b1, 8'hA0, 8'h84, 8'h18);
    rival <= 1'b1;
    step(1'b1, 8'hFF, 8'h84, 8'h38);
    rival <= 1'b0;
    wr(8'h00, 8'h84);
    repeat (40) @(posedge aclk);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    test_done;
  end
endmodule // tb
